// ---- src/fsp_flash_sector_protection.sv ----
// What this block does
// - Load protection byte from flash after reset
// - Config register readable in every mode
// - Polarity bit only clears, never sets
// - Low size writable only while low disabled
// - High size writable only while high disabled
// - Refuse protected program/erase, flag violation
// - Mass erase only with all three set
// - Polarity one protects enabled ranges only
// - Polarity zero protects all but enabled ranges
// - High size code picks range below top
// - Low size code picks range from 4000h
// - Disable bits at 5 and 2
// - Writes allowed in normal modes
// - Disallowed scenario moves are ignored whole
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module fsp_flash_sector_protection (
  input wire logic core_clk_i, // Module bus clock
  input wire logic nrst_i, // Async reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [7:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error, unmapped
  input wire logic mode_special_i, // Special operating mode
  output logic nvm_rd_req_o, // Protection byte fetch
  output logic [15:0] nvm_rd_addr_o, // Fetch address
  input wire logic nvm_rd_ack_i, // Fetch data valid
  input wire logic [7:0] nvm_rd_data_i, // Fetched byte
  input wire logic cmd_valid_i, // Program/erase request
  input wire logic cmd_mass_i, // Request is mass erase
  input wire logic [15:0] cmd_addr_i, // Target address
  output logic cmd_done_o, // Decision pulse
  output logic cmd_refuse_o, // Request refused
  output logic protect_violation_flag_o, // Sticky violation
  output logic irq_o // Interrupt level
);

  ////////////////////////////////////////////////////////////////////
  // Helper functions

  // Start of the high range for a size code
  function automatic logic [15:0] hi_base(input logic [1:0] size);
    logic [15:0] b;
    case (size)
      2'h0: b = fsp_pkg::FSP_HI_BASE0;
      2'h1: b = fsp_pkg::FSP_HI_BASE1;
      2'h2: b = fsp_pkg::FSP_HI_BASE2;
      default: b = fsp_pkg::FSP_HI_BASE3;
    endcase
    return b;
  endfunction

  // End of the low range for a size code
  function automatic logic [15:0] lo_end(input logic [1:0] size);
    logic [15:0] e;
    case (size)
      2'h0: e = fsp_pkg::FSP_LO_END0;
      2'h1: e = fsp_pkg::FSP_LO_END1;
      2'h2: e = fsp_pkg::FSP_LO_END2;
      default: e = fsp_pkg::FSP_LO_END3;
    endcase
    return e;
  endfunction

  // Protection decision for one address
  function automatic logic prot_hit(input logic [7:0] cfg,
                                    input logic [15:0] addr);
    logic in_hi;
    logic in_lo;
    logic sel;
    // Range extends to the top of the map
    in_hi = addr >= hi_base(cfg[fsp_pkg::FSP_B_HS +: 2]);
    in_lo = (addr >= fsp_pkg::FSP_LO_BASE) &&
            (addr <= lo_end(cfg[fsp_pkg::FSP_B_LS +: 2]));
    // A range counts only while its disable bit is zero
    sel = (!cfg[fsp_pkg::FSP_B_HDIS] && in_hi) ||
          (!cfg[fsp_pkg::FSP_B_LDIS] && in_lo);
    // Polarity swaps the meaning of the selected ranges
    if (cfg[fsp_pkg::FSP_B_POPEN]) begin
      return sel;
    end else begin
      return !sel;
    end
  endfunction

  // Scenario number from the polarity and disable bits
  function automatic logic [2:0] scen(input logic [7:0] cfg);
    return {cfg[fsp_pkg::FSP_B_POPEN], cfg[fsp_pkg::FSP_B_HDIS],
            cfg[fsp_pkg::FSP_B_LDIS]};
  endfunction

  // New config value after a software write
  function automatic logic [7:0] cfg_next(input logic [7:0] cur,
                                          input logic [7:0] wr);
    logic [7:0] c;
    c = cur;
    // Polarity may only fall
    c[fsp_pkg::FSP_B_POPEN] = cur[fsp_pkg::FSP_B_POPEN] &
                              wr[fsp_pkg::FSP_B_POPEN];
    // Spare bit is never taken from software
    c[fsp_pkg::FSP_B_HDIS] = wr[fsp_pkg::FSP_B_HDIS];
    c[fsp_pkg::FSP_B_LDIS] = wr[fsp_pkg::FSP_B_LDIS];
    // Size fields frozen once their range is enabled
    if (cur[fsp_pkg::FSP_B_HDIS]) begin
      c[fsp_pkg::FSP_B_HS +: 2] = wr[fsp_pkg::FSP_B_HS +: 2];
    end
    if (cur[fsp_pkg::FSP_B_LDIS]) begin
      c[fsp_pkg::FSP_B_LS +: 2] = wr[fsp_pkg::FSP_B_LS +: 2];
    end
    // Protection only grows; otherwise keep everything
    if (!fsp_pkg::FSP_SCEN_OK[scen(cur)][scen(c)]) begin
      c = cur;
    end
    return c;
  endfunction

  // Address decode for mapped registers
  function automatic logic mapped(input logic [7:0] a);
    return (a == fsp_pkg::FSP_OFF_CFG) || (a == fsp_pkg::FSP_OFF_STAT) ||
           (a == fsp_pkg::FSP_OFF_CLR) || (a == fsp_pkg::FSP_OFF_IEN);
  endfunction

  // Read value of a register, zero for write-only and unmapped
  function automatic logic [31:0] rd_word(input logic [7:0] a,
                                          input logic [7:0] cfg,
                                          input logic [1:0] stat,
                                          input logic [1:0] ien);
    logic [31:0] w;
    w = 32'h0;
    case (a)
      fsp_pkg::FSP_OFF_CFG: begin
        w = {24'h0, cfg};
      end
      fsp_pkg::FSP_OFF_STAT: begin
        w = {30'h0, stat};
      end
      fsp_pkg::FSP_OFF_IEN: begin
        w = {30'h0, ien};
      end
      default: begin
        w = 32'h0;
      end
    endcase
    return w;
  endfunction

  // Scenario code is {polarity, high disable, low disable}:
  //   7 nothing protected
  //   6 low range protected
  //   5 high range protected
  //   4 both ranges protected
  //   3 whole array protected
  //   2 all but the low range protected
  //   1 all but the high range protected
  //   0 all but both ranges protected
  // Allowed moves only ever add protected addresses.

  ////////////////////////////////////////////////////////////////////
  // State

  fsp_pkg::fsp_regs_type r_r;
  fsp_pkg::fsp_regs_type r_nxt;

  // Bus phase decode
  logic apb_setup;
  logic apb_wr;
  // Status clear mask and new events
  logic [1:0] clr;
  logic [1:0] evt;
  // Command decision terms
  logic hit;
  logic mass_ok;
  logic cmd_refuse_now;
  logic [1:0] cmd_evt;
  // Live config fields
  logic cfg_pol;
  logic cfg_hdis;
  logic cfg_ldis;
  logic load_done;
  logic cfg_wr_ok;
  logic open_all;

  // Transfer phases
  assign apb_setup = psel_i && !penable_i;
  assign apb_wr = psel_i && penable_i && r_r.pready && pwrite_i;

  ////////////////////////////////////////////////////////////////////
  // Field decode of the live config

  // Polarity and the two range switches
  assign cfg_pol = r_r.cfg[fsp_pkg::FSP_B_POPEN];
  assign cfg_hdis = r_r.cfg[fsp_pkg::FSP_B_HDIS];
  assign cfg_ldis = r_r.cfg[fsp_pkg::FSP_B_LDIS];

  // Protection byte has arrived from flash
  assign load_done = (r_r.st == fsp_pkg::FSP_ST_RUN);

  // Software may touch the config in normal modes once loaded
  assign cfg_wr_ok = !mode_special_i && load_done;

  // Mass erase needs every protection switch open
  assign open_all = cfg_pol && cfg_hdis && cfg_ldis;

  ////////////////////////////////////////////////////////////////////
  // Command decision

  // Range and mass erase checks; unknown protection counts as full
  always_comb begin
    hit = prot_hit(r_r.cfg, cmd_addr_i);
    mass_ok = open_all;
    cmd_refuse_now = 1'b0;
    cmd_evt = 2'h0;
    if (cmd_valid_i) begin
      if (!load_done) begin
        // Byte not loaded yet, refuse everything
        cmd_refuse_now = 1'b1;
        cmd_evt[fsp_pkg::FSP_EV_VIOL] = 1'b1;
      end else if (cmd_mass_i) begin
        // Mass erase refused unless every switch is open
        cmd_refuse_now = !mass_ok;
        cmd_evt[fsp_pkg::FSP_EV_VIOL] = !mass_ok;
        cmd_evt[fsp_pkg::FSP_EV_MASS] = !mass_ok;
      end else begin
        // Program or sector erase on a protected address
        cmd_refuse_now = hit;
        cmd_evt[fsp_pkg::FSP_EV_VIOL] = hit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Next state

  // Whole next state; pulses default low every cycle
  always_comb begin
    r_nxt = r_r;
    clr = 2'h0;
    evt = 2'h0;
    r_nxt.cmd_done = 1'b0;
    r_nxt.cmd_refuse = 1'b0;
    r_nxt.pready = 1'b0;
    r_nxt.pslverr = 1'b0;
    r_nxt.nvm_addr = fsp_pkg::FSP_NVM_ADDR;

    // Reset sequence: fetch the nonvolatile protection byte
    case (r_r.st)
      fsp_pkg::FSP_ST_LOAD: begin
        r_nxt.nvm_req = 1'b1;
        if (r_r.nvm_req && nvm_rd_ack_i) begin
          r_nxt.cfg = nvm_rd_data_i;
          r_nxt.nvm_req = 1'b0;
          r_nxt.st = fsp_pkg::FSP_ST_RUN;
        end
      end
      fsp_pkg::FSP_ST_RUN: begin
        // One fetch per reset only
        r_nxt.nvm_req = 1'b0;
      end
      default: begin
        // Unreachable, restart the fetch
        r_nxt.st = fsp_pkg::FSP_ST_LOAD;
      end
    endcase

    // Setup cycle: answer in the first access cycle
    if (apb_setup) begin
      r_nxt.pready = 1'b1;
      r_nxt.pslverr = !mapped(paddr_i);
      r_nxt.prdata = 32'h0;
      if (!pwrite_i) begin
        r_nxt.prdata = rd_word(paddr_i, r_r.cfg, r_r.stat, r_r.ien);
      end
    end

    // Access edge: writes take effect
    if (apb_wr) begin
      case (paddr_i)
        fsp_pkg::FSP_OFF_CFG: begin
          // Normal modes only, and not before the load
          if (cfg_wr_ok) begin
            r_nxt.cfg = cfg_next(r_r.cfg, pwdata_i[7:0]);
          end
        end
        fsp_pkg::FSP_OFF_CLR: clr = pwdata_i[1:0];
        fsp_pkg::FSP_OFF_IEN: r_nxt.ien = pwdata_i[1:0];
        default: clr = 2'h0;
      endcase
    end

    // Command answer one cycle after the request
    if (cmd_valid_i) begin
      r_nxt.cmd_done = 1'b1;
      r_nxt.cmd_refuse = cmd_refuse_now;
      evt = cmd_evt;
    end

    // Sticky status, a new event wins over a clear
    r_nxt.stat = (r_r.stat & ~clr) | evt;
    r_nxt.irq = |(r_nxt.stat & r_nxt.ien);
  end

  ////////////////////////////////////////////////////////////////////
  // Registers

  // Whole state in one register, config reset to erased flash
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_r <= fsp_pkg::FSP_REGS_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  // Bus answer
  assign prdata_o = r_r.prdata;
  assign pready_o = r_r.pready;
  assign pslverr_o = r_r.pslverr;

  // Protection byte fetch
  assign nvm_rd_req_o = r_r.nvm_req;
  assign nvm_rd_addr_o = r_r.nvm_addr;

  // Command answer
  assign cmd_done_o = r_r.cmd_done;
  assign cmd_refuse_o = r_r.cmd_refuse;

  // Sticky flag and interrupt level
  assign protect_violation_flag_o = r_r.stat[fsp_pkg::FSP_EV_VIOL];
  assign irq_o = r_r.irq;

endmodule

`default_nettype wire

// ---- include/fsp_pkg.sv ----
package fsp_pkg;

  // APB byte offsets
  localparam logic [7:0] FSP_OFF_CFG = 8'h04;
  localparam logic [7:0] FSP_OFF_STAT = 8'h10;
  localparam logic [7:0] FSP_OFF_CLR = 8'h14;
  localparam logic [7:0] FSP_OFF_IEN = 8'h18;

  // Field positions in sector_protection_config
  localparam int FSP_B_POPEN = 7;
  localparam int FSP_B_NV = 6;
  localparam int FSP_B_HDIS = 5;
  localparam int FSP_B_HS = 3;
  localparam int FSP_B_LDIS = 2;
  localparam int FSP_B_LS = 0;

  // Erased flash value, held until the reset load completes
  localparam logic [7:0] FSP_CFG_RST = 8'hff;

  // Nonvolatile location of the protection byte
  localparam logic [15:0] FSP_NVM_ADDR = 16'hff0d;

  // High range start per size code
  localparam logic [15:0] FSP_HI_BASE0 = 16'hf800;
  localparam logic [15:0] FSP_HI_BASE1 = 16'hf000;
  localparam logic [15:0] FSP_HI_BASE2 = 16'he000;
  localparam logic [15:0] FSP_HI_BASE3 = 16'hc000;

  // Low range start and end per size code
  localparam logic [15:0] FSP_LO_BASE = 16'h4000;
  localparam logic [15:0] FSP_LO_END0 = 16'h43ff;
  localparam logic [15:0] FSP_LO_END1 = 16'h47ff;
  localparam logic [15:0] FSP_LO_END2 = 16'h4fff;
  localparam logic [15:0] FSP_LO_END3 = 16'h5fff;

  // Allowed scenario moves, row = from, bit = to
  localparam logic [7:0][7:0] FSP_SCEN_OK = {
    8'hff, 8'h5a, 8'h3c, 8'h18, 8'h08, 8'h0c, 8'h0a, 8'h0f
  };

  // Status and enable bits
  localparam int FSP_EV_VIOL = 0;
  localparam int FSP_EV_MASS = 1;

  typedef enum logic {FSP_ST_LOAD, FSP_ST_RUN} fsp_state_type;

  typedef struct packed {
    fsp_state_type st;
    logic nvm_req;
    logic [15:0] nvm_addr;
    logic [7:0] cfg;
    logic [1:0] stat;
    logic [1:0] ien;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic cmd_done;
    logic cmd_refuse;
  } fsp_regs_type;

  localparam fsp_regs_type FSP_REGS_RST = '{
    st: FSP_ST_LOAD, nvm_addr: FSP_NVM_ADDR, cfg: FSP_CFG_RST, default: '0
  };

endpackage

// ---- tb/fsp_nvm_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module fsp_nvm_model #(
  parameter logic [7:0] BYTE_VAL = 8'hff, // Spare bit erased
  parameter int LAT = 3
) (
  input wire logic clk_i, // Clock
  input wire logic nrst_i, // Reset
  input wire logic req_i, // Fetch request
  input wire logic [15:0] addr_i, // Fetch address
  output logic ack_o, // Data valid
  output logic [7:0] data_o // Fetched byte
);
  int cnt;
  // Answer after LAT cycles, scramble the bus otherwise
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 0;
      ack_o <= 1'b0;
      data_o <= ~BYTE_VAL;
    end else if (req_i && !ack_o && cnt >= LAT) begin
      ack_o <= 1'b1;
      data_o <= (addr_i == fsp_pkg::FSP_NVM_ADDR) ? BYTE_VAL : 8'h00;
      cnt <= 0;
    end else begin
      ack_o <= 1'b0;
      data_o <= ~data_o;
      cnt <= req_i ? cnt + 1 : 0;
    end
  end
endmodule
`default_nettype wire

// ---- tb/fsp_flash_sector_protection_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module fsp_flash_sector_protection_sva (
  input wire logic core_clk_i, // Clock
  input wire logic nrst_i, // Reset
  input wire logic psel_i, // Select
  input wire logic penable_i, // Enable
  input wire logic pready_o, // Ready
  input wire logic pslverr_o, // Error
  input wire logic nvm_rd_req_o, // Fetch
  input wire logic [15:0] nvm_rd_addr_o, // Fetch address
  input wire logic nvm_rd_ack_i, // Fetch ack
  input wire logic cmd_valid_i, // Request
  input wire logic cmd_done_o, // Decision
  input wire logic cmd_refuse_o, // Refused
  input wire logic protect_violation_flag_o // Sticky flag
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////
  // Decision timing and violation flag
  done_next_a: assert property (cmd_valid_i |=> cmd_done_o)
    else $error("no decision after request");
  done_cause_a: assert property (cmd_done_o |-> $past(cmd_valid_i))
    else $error("decision without request");
  refuse_qual_a: assert property (cmd_refuse_o |-> cmd_done_o)
    else $error("refusal outside decision");
  viol_set_a: assert property (cmd_refuse_o |-> protect_violation_flag_o)
    else $error("refusal without violation flag");
  viol_rise_a: assert property ($rose(protect_violation_flag_o) |-> cmd_refuse_o)
    else $error("violation flag without refusal");
  ////////////////////////////////////////
  // Register access and protection byte fetch
  ready_next_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  fetch_addr_a: assert property (nvm_rd_req_o |-> nvm_rd_addr_o == fsp_pkg::FSP_NVM_ADDR)
    else $error("wrong fetch address");
  fetch_once_a: assert property (nvm_rd_req_o && nvm_rd_ack_i |=> (!nvm_rd_req_o)[*8])
    else $error("fetch repeated");
  // Main scenarios
  cover property (cmd_refuse_o);
  cover property (nvm_rd_req_o && nvm_rd_ack_i);
  cover property (pslverr_o);
endmodule
bind fsp_flash_sector_protection fsp_flash_sector_protection_sva chk_u (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .nvm_rd_req_o(nvm_rd_req_o),
  .nvm_rd_addr_o(nvm_rd_addr_o), .nvm_rd_ack_i(nvm_rd_ack_i), .cmd_valid_i(cmd_valid_i),
  .cmd_done_o(cmd_done_o), .cmd_refuse_o(cmd_refuse_o),
  .protect_violation_flag_o(protect_violation_flag_o)
);
`default_nettype wire

// ---- tb/fsp_flash_sector_protection_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module fsp_flash_sector_protection_tb_top;
  localparam logic [7:0] CFG = fsp_pkg::FSP_OFF_CFG;
  localparam logic [7:0] STA = fsp_pkg::FSP_OFF_STAT;
  localparam logic [7:0] CLR = fsp_pkg::FSP_OFF_CLR;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, spec = 1'b0, cv = 1'b0, cm = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [15:0] ca = 16'h0000;
  logic [31:0] pwd = 32'h0, prd, q;
  logic rdy, err, e, nreq, nack, done, refu, viol, irq;
  logic [15:0] nadr;
  logic [7:0] ndat;
  int errors = 0;
  int checked = 0;
  // Clock
  always #2.5 clk = ~clk;
  fsp_flash_sector_protection dut_u (.core_clk_i(clk), .nrst_i(nrst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(rdy), .pslverr_o(err), .mode_special_i(spec), .nvm_rd_req_o(nreq),
    .nvm_rd_addr_o(nadr), .nvm_rd_ack_i(nack), .nvm_rd_data_i(ndat), .cmd_valid_i(cv),
    .cmd_mass_i(cm), .cmd_addr_i(ca), .cmd_done_o(done), .cmd_refuse_o(refu),
    .protect_violation_flag_o(viol), .irq_o(irq));
  fsp_nvm_model nvm_u (.clk_i(clk), .nrst_i(nrst), .req_i(nreq), .addr_i(nadr),
    .ack_o(nack), .data_o(ndat));
  ////////////////////////////////////////
  task automatic end_sim;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      $display("unexpected %s exp %h got %h", nm, x, g);
      errors++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (rdy !== 1'b1) begin
      errors++;
      end_sim;
    end
    q = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("read", x, q);
  endtask
  task automatic cmd(input logic [15:0] a, input logic m, input logic x);
    @(posedge clk);
    cv <= 1'b1;
    cm <= m;
    ca <= a;
    @(posedge clk);
    cv <= 1'b0;
    @(posedge clk);
    chk("done", 32'h1, 32'(done));
    chk("refuse", 32'(x), 32'(refu));
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    cmd(16'h0000, 1'b0, 1'b1);
    for (int i = 0; nreq !== 1'b0; i++) begin
      if (i > 40) begin
        errors++;
        end_sim;
      end
      @(posedge clk);
    end
    rd(CFG, 32'hff);
    rd(STA, 32'h1);
    chk("irq", 32'h0, 32'(irq));
    apb(1'b1, CLR, 32'h3);
    apb(1'b1, fsp_pkg::FSP_OFF_IEN, 32'h1);
    spec <= 1'b1;
    apb(1'b1, CFG, 32'h0);
    rd(CFG, 32'hff);
    spec <= 1'b0;
    cmd(16'h8000, 1'b1, 1'b0);
    apb(1'b1, CFG, 32'hea);
    rd(CFG, 32'hea);
    cmd(16'h4fff, 1'b0, 1'b1);
    chk("irq", 32'h1, 32'(irq));
    cmd(16'h5000, 1'b0, 1'b0);
    cmd(16'h8000, 1'b1, 1'b1);
    rd(STA, 32'h3);
    apb(1'b1, CLR, 32'h3);
    @(posedge clk);
    chk("irq", 32'h0, 32'(irq));
    apb(1'b1, CFG, 32'he9);
    rd(CFG, 32'hea);
    apb(1'b1, CFG, 32'h6a);
    rd(CFG, 32'hea);
    apb(1'b1, CFG, 32'hd2);
    rd(CFG, 32'hd2);
    cmd(16'he000, 1'b0, 1'b1);
    cmd(16'hdfff, 1'b0, 1'b0);
    apb(1'b1, CFG, 32'hca);
    rd(CFG, 32'hd2);
    apb(1'b1, CFG, 32'h76);
    rd(CFG, 32'h76);
    cmd(16'h2000, 1'b0, 1'b1);
    apb(1'b1, CFG, 32'hf6);
    rd(CFG, 32'h76);
    rd(8'h08, 32'h0);
    chk("pslverr", 32'h1, 32'(e));
    end_sim;
  end
endmodule
`default_nettype wire
